// file: verilog/pcc_master.sv
// Purpose: master end; software registers build and send channel requests
// Assumes: device answers each request once with rsp_valid
// Notes:   request held until the response arrives
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module pcc_master (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  pcc_if.master            chan,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [15:0]      rdata_out,
  output logic             irq_out
);
  typedef enum logic [0:0] {PCM_IDLE, PCM_BUSY} pcm_state_e;
  typedef struct packed {
    pcm_state_e  st;
    logic [15:0] cmd;
    logic [15:0] pnum;
    logic [15:0] sub;
    logic [15:0] vhi;
    logic [15:0] vlo;
    logic [15:0] link;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic [63:0] req;
    logic [47:0] rsp;
    logic [15:0] rd;
    logic        irq;
  } pcm_s;
  pcm_s        s_reg;
  pcm_s        s_next;
  logic [8:0]  pg;
  logic [16:0] off;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [2:0]  ev;
  // next state
  always_comb
  begin
    s_next = s_reg;
    ev = 3'h0;
    pg = pcc_pkg::number_to_page(s_reg.pnum);
    off = pcc_pkg::page_to_offset(pg[7:0]);
    hi = 16'h0000;
    lo = 16'h0000;
    // cmd: bits 3..0 identifier, 5..4 format, bit 15 go
    case (s_reg.cmd[5:4])
      pcc_pkg::FMT_8:  lo = {8'h00, s_reg.vlo[7:0]};
      pcc_pkg::FMT_16: lo = s_reg.vlo;
      pcc_pkg::FMT_32:
      begin
        hi = s_reg.vhi;
        lo = s_reg.vlo;
      end
      default:
      begin
        hi = s_reg.vhi;
        lo = {pcc_pkg::DRIVE_OBJ, s_reg.link[pcc_pkg::SRCIDX_MSB:0]};
      end
    endcase
    if (s_reg.cmd[3:0] == pcc_pkg::REQ_READ_ARR)
    begin
      hi = 16'h0000;
      lo = 16'h0000;
    end
    // register writes
    if (wr_in)
    begin
      if (addr_in == pcc_pkg::R_CMD) s_next.cmd = wdata_in;
      else if (addr_in == pcc_pkg::R_PNUM) s_next.pnum = wdata_in;
      else if (addr_in == pcc_pkg::R_SUB) s_next.sub = wdata_in;
      else if (addr_in == pcc_pkg::R_VAL_HI) s_next.vhi = wdata_in;
      else if (addr_in == pcc_pkg::R_VAL_LO) s_next.vlo = wdata_in;
      else if (addr_in == pcc_pkg::R_MASK) s_next.mask = wdata_in[2:0];
      else if (addr_in == pcc_pkg::R_LINK) s_next.link = wdata_in;
    end
    case (s_reg.st)
      PCM_IDLE:
      begin
        if (s_reg.cmd[15])
        begin
          // a go written in this very cycle is kept for the next request
          s_next.cmd[15] = wr_in && addr_in == pcc_pkg::R_CMD && wdata_in[15];
          if (!pg[8]) ev[pcc_pkg::ST_BADNUM] = 1'b1;
          else
          begin
            s_next.req = {s_reg.cmd[3:0], 1'b0,
                          11'(s_reg.pnum - off[15:0]),
                          pg[7:0], s_reg.sub[7:0],
                          hi, lo};
            s_next.st = PCM_BUSY;
          end
        end
      end
      PCM_BUSY:
      begin
        if (chan.rsp_valid)
        begin
          s_next.rsp = {chan.rsp_word[0], chan.rsp_word[2], chan.rsp_word[3]};
          ev[pcc_pkg::ST_DONE] = 1'b1;
          if (chan.rsp_word[0][15:12] == pcc_pkg::RSP_ERROR) ev[pcc_pkg::ST_ERR] = 1'b1;
          s_next.st = PCM_IDLE;
        end
      end
      default: s_next.st = PCM_IDLE;
    endcase
    // sticky status, set wins over write-one clear
    if (wr_in && addr_in == pcc_pkg::R_STATUS) s_next.stat = s_reg.stat & ~wdata_in[2:0];
    s_next.stat = s_next.stat | ev;
    s_next.irq = |(s_next.stat & s_next.mask);
    // read data one cycle later
    s_next.rd = 16'h0000;
    if (rd_in)
    begin
      if (addr_in == pcc_pkg::R_CMD) s_next.rd = s_reg.cmd;
      else if (addr_in == pcc_pkg::R_PNUM) s_next.rd = s_reg.pnum;
      else if (addr_in == pcc_pkg::R_SUB) s_next.rd = s_reg.sub;
      else if (addr_in == pcc_pkg::R_VAL_HI) s_next.rd = s_reg.vhi;
      else if (addr_in == pcc_pkg::R_VAL_LO) s_next.rd = s_reg.vlo;
      else if (addr_in == pcc_pkg::R_STATUS) s_next.rd = {12'h000, s_reg.st == PCM_BUSY, s_reg.stat};
      else if (addr_in == pcc_pkg::R_MASK) s_next.rd = {13'h0000, s_reg.mask};
      else if (addr_in == pcc_pkg::R_RSP_HDR) s_next.rd = s_reg.rsp[47:32];
      else if (addr_in == pcc_pkg::R_RSP_HI) s_next.rd = s_reg.rsp[31:16];
      else if (addr_in == pcc_pkg::R_RSP_LO) s_next.rd = s_reg.rsp[15:0];
      else if (addr_in == pcc_pkg::R_LINK) s_next.rd = s_reg.link;
    end
  end
  // state register
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) s_reg <= '0;
    else s_reg <= s_next;
  end
  // outputs
  assign chan.req_valid = (s_reg.st == PCM_BUSY);
  assign chan.req_word[0] = s_reg.req[63:48];
  assign chan.req_word[1] = s_reg.req[47:32];
  assign chan.req_word[2] = s_reg.req[31:16];
  assign chan.req_word[3] = s_reg.req[15:0];
  assign rdata_out = s_reg.rd;
  assign irq_out = s_reg.irq;
endmodule : pcc_master

// file: pkg/pcc_pkg.sv
// Purpose: constants and functions shared by both ends of the parameter channel codec
// Assumes: four-word channel, 16-bit words, one clock
// Notes:   Operation list below
// Operation
// - numbers below 2000 sent unchanged, page zero
// - larger numbers send remainder, offset in page
// - page codes map to seven fixed offsets
// - element index goes in subindex byte
// - 8-bit value in low byte, upper zero
// - 16-bit value fills the low word
// - 32-bit value split high then low word
// - interconnect: source high, object bits 10-15
// - interconnect: source index in low bits 0-9
// - word order header, index, high, low
// - identifier 6 reads one array element
// - identifier 7 writes one array word
// - master zeroes value words on reads
// - master sets drive object to 63
// - failed request answers 7 with error number
// - unknown parameter gives error number 0x00
package pcc_pkg;
  // ---------------------------------------------------------------
  // channel layout
  // ---------------------------------------------------------------
  localparam int          WORDS        = 4;
  localparam int          ID_MSB       = 15;
  localparam int          ID_LSB       = 12;
  localparam int          PNU_MSB      = 10;
  localparam int          PAGE_MSB     = 15;
  localparam int          PAGE_LSB     = 8;
  localparam int          SUB_MSB      = 7;
  localparam int          OBJ_LSB      = 10;
  localparam int          SRCIDX_MSB   = 9;
  localparam logic [15:0] RANGE_SPAN   = 16'h07D0;
  localparam logic [3:0]  REQ_READ_ARR = 4'h6;
  localparam logic [3:0]  REQ_WR_ARR   = 4'h7;
  localparam logic [3:0]  RSP_ARR_WORD = 4'h4;
  localparam logic [3:0]  RSP_ERROR    = 4'h7;
  localparam logic [15:0] ERR_NO_PARAM = 16'h0000;
  localparam logic [15:0] ERR_NO_REQ   = 16'h006A;
  localparam logic [5:0]  DRIVE_OBJ    = 6'h3F;
  localparam logic [15:0] PARAM_LIMIT  = 16'h7CCF;
  // value formats
  localparam logic [1:0]  FMT_8        = 2'h0;
  localparam logic [1:0]  FMT_16       = 2'h1;
  localparam logic [1:0]  FMT_32       = 2'h2;
  localparam logic [1:0]  FMT_LINK     = 2'h3;
  // status and interrupt bits of the master
  localparam int          ST_DONE      = 0;
  localparam int          ST_ERR       = 1;
  localparam int          ST_BADNUM    = 2;
  // master register offsets
  localparam logic [3:0]  R_CMD        = 4'h0;
  localparam logic [3:0]  R_PNUM       = 4'h1;
  localparam logic [3:0]  R_SUB        = 4'h2;
  localparam logic [3:0]  R_VAL_HI     = 4'h3;
  localparam logic [3:0]  R_VAL_LO     = 4'h4;
  localparam logic [3:0]  R_STATUS     = 4'h5;
  localparam logic [3:0]  R_MASK       = 4'h6;
  localparam logic [3:0]  R_RSP_HDR    = 4'h7;
  localparam logic [3:0]  R_RSP_HI     = 4'h8;
  localparam logic [3:0]  R_RSP_LO     = 4'h9;
  localparam logic [3:0]  R_LINK       = 4'hA;

  // page code to offset; valid flag in bit 16
  function automatic logic [16:0] page_to_offset(input logic [7:0] page);
    logic [16:0] r;
    r = 17'h00000;
    case (page)
      8'h00:   r = {1'b1, 16'h0000};
      8'h80:   r = {1'b1, 16'h07D0};
      8'h90:   r = {1'b1, 16'h1770};
      8'h20:   r = {1'b1, 16'h1F40};
      8'hA0:   r = {1'b1, 16'h2710};
      8'h50:   r = {1'b1, 16'h4E20};
      8'hF0:   r = {1'b1, 16'h7530};
      default: r = 17'h00000;
    endcase
    return r;
  endfunction : page_to_offset

  // number to page code; valid flag in bit 8
  function automatic logic [8:0] number_to_page(input logic [15:0] num);
    logic [8:0] r;
    r = 9'h000;
    if (num < 16'h07D0) r = {1'b1, 8'h00};
    else if (num < 16'h0FA0) r = {1'b1, 8'h80};
    else if (num >= 16'h1770 && num < 16'h1F40) r = {1'b1, 8'h90};
    else if (num >= 16'h1F40 && num < 16'h2710) r = {1'b1, 8'h20};
    else if (num >= 16'h2710 && num < 16'h2EE0) r = {1'b1, 8'hA0};
    else if (num >= 16'h4E20 && num < 16'h55F0) r = {1'b1, 8'h50};
    else if (num >= 16'h7530 && num < 16'h7D00) r = {1'b1, 8'hF0};
    return r;
  endfunction : number_to_page
endpackage : pcc_pkg

// file: pkg/pcc_if.sv
// Purpose: channel between master and device ends
// Assumes: both ends on ref_clk_in
// Notes:   request words held while req_valid, response pulses rsp_valid
`timescale 1ns/1ps
interface pcc_if;
  logic        req_valid;
  logic [15:0] req_word [4];
  logic        rsp_valid;
  logic [15:0] rsp_word [4];
  modport master (output req_valid, output req_word, input rsp_valid, input rsp_word);
  modport device (input req_valid, input req_word, output rsp_valid, output rsp_word);
endinterface : pcc_if

// file: verilog/pcc_device.sv
// Purpose: device end; decodes requests against a small array parameter store
// Assumes: master holds request words stable while req_valid
// Notes:   one response per request, one cycle after it is taken, two cycles after req_valid rises
`timescale 1ns/1ps
module pcc_device (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  pcc_if.device            chan,
  input  wire logic [15:0] store_base_in,
  output logic             wr_pulse_out,
  output logic [15:0]      wr_number_out,
  output logic [7:0]       wr_sub_out,
  output logic [15:0]      wr_data_out
);
  typedef enum logic [1:0] {PCD_IDLE, PCD_EXEC, PCD_WAIT} pcd_state_e;
  typedef struct packed {
    pcd_state_e  st;
    logic [15:0] num;
    logic [7:0]  sub;
    logic        ok;
    logic [3:0]  id;
    logic [15:0] val;
    logic        rv;
    logic [63:0] rsp;
    logic        wp;
    logic [15:0] wn;
    logic [7:0]  ws;
    logic [15:0] wd;
  } pcd_s;
  pcd_s        s_reg;
  pcd_s        s_next;
  logic [15:0] mem [16];
  logic [16:0] dec;
  logic [15:0] h0;
  logic [15:0] h1;
  // ---------------------------------------------------------------
  // element store; parameters store_base_in .. +15, subindex not decoded
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (s_reg.wp) mem[s_reg.ws[3:0]] <= s_reg.wd;
  end
  // next state
  always_comb
  begin
    s_next = s_reg;
    h0 = chan.req_word[0];
    h1 = chan.req_word[1];
    dec = pcc_pkg::page_to_offset(h1[pcc_pkg::PAGE_MSB:pcc_pkg::PAGE_LSB]);
    s_next.rv = 1'b0;
    s_next.wp = 1'b0;
    case (s_reg.st)
      PCD_IDLE:
      begin
        if (chan.req_valid)
        begin
          s_next.id = h0[pcc_pkg::ID_MSB:pcc_pkg::ID_LSB];
          s_next.num = {5'h00, h0[pcc_pkg::PNU_MSB:0]} + dec[15:0];
          s_next.ok = dec[16];
          s_next.sub = h1[pcc_pkg::SUB_MSB:0];
          s_next.val = chan.req_word[3];
          s_next.st = PCD_EXEC;
        end
      end
      PCD_EXEC:
      begin
        s_next.rv = 1'b1;
        s_next.st = PCD_WAIT;
        if (!s_reg.ok || s_reg.num < store_base_in || s_reg.num - store_base_in > 16'h000F)
          s_next.rsp = {pcc_pkg::RSP_ERROR, h0[11:0], h1, 16'h0000,
                        pcc_pkg::ERR_NO_PARAM};
        else if (s_reg.id == pcc_pkg::REQ_READ_ARR)
          s_next.rsp = {pcc_pkg::RSP_ARR_WORD, h0[11:0], h1, 16'h0000,
                        mem[s_reg.num[3:0] - store_base_in[3:0]]};
        else if (s_reg.id == pcc_pkg::REQ_WR_ARR)
        begin
          s_next.wp = 1'b1;
          s_next.wn = s_reg.num;
          s_next.ws = {4'h0, s_reg.num[3:0] - store_base_in[3:0]};
          s_next.wd = s_reg.val;
          s_next.rsp = {pcc_pkg::RSP_ARR_WORD, h0[11:0], h1, 16'h0000, s_reg.val};
        end
        else
          s_next.rsp = {pcc_pkg::RSP_ERROR, h0[11:0], h1, 16'h0000,
                        pcc_pkg::ERR_NO_REQ};
      end
      PCD_WAIT:
      begin
        if (!chan.req_valid) s_next.st = PCD_IDLE;
      end
      default: s_next.st = PCD_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in) s_reg <= '0;
    else s_reg <= s_next;
  end
  // outputs straight from flops
  assign chan.rsp_valid = s_reg.rv;
  assign chan.rsp_word[0] = s_reg.rsp[63:48];
  assign chan.rsp_word[1] = s_reg.rsp[47:32];
  assign chan.rsp_word[2] = s_reg.rsp[31:16];
  assign chan.rsp_word[3] = s_reg.rsp[15:0];
  assign wr_pulse_out = s_reg.wp;
  assign wr_number_out = s_reg.wn;
  assign wr_sub_out = s_reg.ws;
  assign wr_data_out = s_reg.wd;
endmodule : pcc_device

// file: verification/pcc_checker.sv
// Purpose: concurrent checks on the channel between master and device ends
// Assumes: one clock, synchronous active-low reset
// Notes:   instantiated beside the channel interface, no bind
`timescale 1ns/1ps
module pcc_checker (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        req_valid,
  input wire logic [15:0] req_word [4],
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_word [4]
);
  // ---------------------------------------------------------------
  // handshake steps
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // request newly raised
  sequence s_new_req;
    $rose(req_valid);
  endsequence
  // answer pulse two cycles on, request dropped after it
  sequence s_answer;
    ##2 rsp_valid ##1 (!rsp_valid && !req_valid);
  endsequence
  // ---------------------------------------------------------------
  // channel assertions
  // ---------------------------------------------------------------
  a_answer_timing: assert property (s_new_req |-> s_answer)
    else $error("answer not two cycles after request");
  a_req_held: assert property (
    req_valid && !rsp_valid |=> req_valid && $stable(req_word[0]) && $stable(req_word[1])
    && $stable(req_word[2]) && $stable(req_word[3]))
    else $error("request words moved while pending");
  a_rsp_pending: assert property (rsp_valid |-> req_valid)
    else $error("answer without request");
  a_page_listed: assert property (
    req_valid |-> req_word[1][15:8] inside {8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0})
    else $error("unlisted page code sent");
  a_number_span: assert property (req_valid |-> req_word[0][10:0] < 11'h7D0)
    else $error("number field beyond range span");
  a_read_zeroed: assert property (
    req_valid && req_word[0][15:12] == 4'h6
    |-> req_word[2] == 16'h0000 && req_word[3] == 16'h0000)
    else $error("read request carries value words");
  a_rsp_echo: assert property (
    rsp_valid |-> rsp_word[0][11:0] == req_word[0][11:0] && rsp_word[1] == req_word[1])
    else $error("answer does not echo request");
  a_read_answer: assert property (
    rsp_valid && req_word[0][15:12] == 4'h6 |-> rsp_word[0][15:12] inside {4'h4, 4'h7})
    else $error("read answered with wrong identifier");
  a_unsupported: assert property (
    rsp_valid && !(req_word[0][15:12] inside {4'h6, 4'h7})
    |-> rsp_word[0][15:12] == 4'h7 && rsp_word[3] == 16'h006A)
    else $error("unsupported request not refused");
endmodule : pcc_checker

// file: verification/testbench.sv
// Purpose: self-checking bench joining master and device ends
// Assumes: store base at 8000, mask bit high enables interrupt
// Notes:   table rows first, then interrupt, refusal and reset cases
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [15:0] n, s, c, h, l, k, w0, w1, w2, w3, r0, rl;} pcc_row_s;
  logic        ref_clk_in, rst_n_in, wr_in, rd_in, irq_out, wr_pulse_out;
  logic [3:0]  addr_in;
  logic [7:0]  wr_sub_out;
  logic [15:0] wdata_in, rdata_out, wr_number_out, wr_data_out, store_base_in;
  int          error_cnt = 0;
  int          check_count = 0;
  pcc_row_s    rows [11];
  pcc_if chan ();
  pcc_master u_pcc_master (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chan(chan),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out));
  pcc_device u_pcc_device (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chan(chan),
    .store_base_in(store_base_in), .wr_pulse_out(wr_pulse_out),
    .wr_number_out(wr_number_out), .wr_sub_out(wr_sub_out), .wr_data_out(wr_data_out));
  pcc_checker u_pcc_checker (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .req_valid(chan.req_valid), .req_word(chan.req_word),
    .rsp_valid(chan.rsp_valid), .rsp_word(chan.rsp_word));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask : wr_reg
  // register read, data compared in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 chk(rdata_out, e);
  endtask : rd_chk
  // one table row: set up, send, compare words on the channel
  task automatic run(input pcc_row_s r);
    int n;
    wr_reg(pcc_pkg::R_PNUM, r.n);
    wr_reg(pcc_pkg::R_SUB, r.s);
    wr_reg(pcc_pkg::R_VAL_HI, r.h);
    wr_reg(pcc_pkg::R_VAL_LO, r.l);
    wr_reg(pcc_pkg::R_LINK, r.k);
    wr_reg(pcc_pkg::R_CMD, r.c | 16'h8000);
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    while (chan.rsp_valid !== 1'b1 && n < 20);
    chk({15'h0000, chan.rsp_valid}, 16'h0001);
    chk({15'h0000, wr_pulse_out}, {15'h0000, r.c[3:0] == 4'h7 && r.r0[15:12] == 4'h4});
    chk(chan.req_word[0], r.w0);
    chk(chan.req_word[1], r.w1);
    chk(chan.req_word[2], r.w2);
    chk(chan.req_word[3], r.w3);
    chk(chan.rsp_word[0], r.r0);
    chk(chan.rsp_word[1], r.w1);
    chk(chan.rsp_word[2], 16'h0000);
    if (r.c[3:0] != 4'h7 || r.r0[15:12] == 4'h7)
      rd_chk(pcc_pkg::R_RSP_LO, r.rl);
  endtask : run
  // verdict and end of run
  task automatic final_report();
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // clock of 40 ns
  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // watchdog against a hang
  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial
  begin
    rst_n_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 4'h0;
    wdata_in = 16'h0000; store_base_in = 16'h1F40;
    rows = '{
      '{16'h1F43, 16'h1, 16'h07, 16'h0, 16'h12AB, 16'h0, 16'h7003, 16'h2001, 16'h0, 16'h00AB,
        16'h4003, 16'h0},
      '{16'h07D5, 16'h0, 16'h17, 16'h0, 16'hBEEF, 16'h0, 16'h7005, 16'h8000, 16'h0, 16'hBEEF,
        16'h7005, 16'h0},
      '{16'h1F44, 16'h0, 16'h27, 16'h1234, 16'h5678, 16'h0, 16'h7004, 16'h2000, 16'h1234,
        16'h5678, 16'h4004, 16'h0},
      '{16'h0348, 16'h1, 16'h37, 16'h02D2, 16'h0, 16'h2, 16'h7348, 16'h0001, 16'h02D2, 16'hFC02,
        16'h7348, 16'h0},
      '{16'h1F43, 16'h1, 16'h16, 16'h5555, 16'h5555, 16'h0, 16'h6003, 16'h2001, 16'h0, 16'h0,
        16'h4003, 16'h00AB},
      '{16'h7531, 16'h2, 16'h16, 16'h0, 16'h0, 16'h0, 16'h6001, 16'hF002, 16'h0, 16'h0,
        16'h7001, 16'h0},
      '{16'h1EA1, 16'h2, 16'h16, 16'h0, 16'h0, 16'h0, 16'h6731, 16'h9002, 16'h0, 16'h0,
        16'h7731, 16'h0},
      '{16'h1F44, 16'h0, 16'h12, 16'h0, 16'h1111, 16'h0, 16'h2004, 16'h2000, 16'h0, 16'h1111,
        16'h7004, 16'h006A},
      '{16'h2715, 16'h0, 16'h16, 16'h0, 16'h0, 16'h0, 16'h6005, 16'hA000, 16'h0, 16'h0,
        16'h7005, 16'h0},
      '{16'h4E2A, 16'h0, 16'h16, 16'h0, 16'h0, 16'h0, 16'h600A, 16'h5000, 16'h0, 16'h0,
        16'h700A, 16'h0},
      '{16'h1F44, 16'h0, 16'h16, 16'h0, 16'h0, 16'h0, 16'h6004, 16'h2000, 16'h0, 16'h0,
        16'h4004, 16'h5678}};
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_chk(pcc_pkg::R_STATUS, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    foreach (rows[i]) run(rows[i]);
    chk(wr_number_out, 16'h1F44);
    chk(wr_data_out, 16'h5678);
    chk({8'h00, wr_sub_out}, 16'h0004);
    rd_chk(pcc_pkg::R_RSP_HDR, 16'h4004);
    rd_chk(pcc_pkg::R_RSP_HI, 16'h0000);
    rd_chk(pcc_pkg::R_STATUS, 16'h0003);
    chk({15'h0000, irq_out}, 16'h0000);
    wr_reg(pcc_pkg::R_MASK, 16'h0001);
    rd_chk(pcc_pkg::R_MASK, 16'h0001);
    chk({15'h0000, irq_out}, 16'h0001);
    wr_reg(pcc_pkg::R_STATUS, 16'h0001);
    rd_chk(pcc_pkg::R_STATUS, 16'h0002);
    chk({15'h0000, irq_out}, 16'h0000);
    // number in no listed range is never sent
    wr_reg(pcc_pkg::R_PNUM, 16'h0FA0);
    wr_reg(pcc_pkg::R_CMD, 16'h8016);
    rd_chk(pcc_pkg::R_PNUM, 16'h0FA0);
    rd_chk(pcc_pkg::R_STATUS, 16'h0006);
    chk({15'h0000, chan.req_valid}, 16'h0000);
    wr_reg(pcc_pkg::R_MASK, 16'h0004);
    rd_chk(pcc_pkg::R_MASK, 16'h0004);
    chk({15'h0000, irq_out}, 16'h0001);
    wr_reg(pcc_pkg::R_STATUS, 16'h0007);
    rd_chk(pcc_pkg::R_STATUS, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    // reset in mid-run with a flag raised clears all state but the element store
    wr_reg(pcc_pkg::R_MASK, 16'h0007);
    wr_reg(pcc_pkg::R_CMD, 16'h8016);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    #1 chk({15'h0000, irq_out}, 16'h0001);
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    #1 chk({15'h0000, irq_out}, 16'h0000);
    chk(wr_number_out, 16'h0000);
    chk(chan.rsp_word[0], 16'h0000);
    rd_chk(pcc_pkg::R_STATUS, 16'h0000);
    rd_chk(pcc_pkg::R_MASK, 16'h0000);
    rd_chk(pcc_pkg::R_PNUM, 16'h0000);
    final_report();
  end
endmodule : testbench
